// file: timer16_regs.svh
// constants for the 16-bit compare/capture timer
`ifndef TIMER16_REGS_SVH
`define TIMER16_REGS_SVH
`define TMR_WIDTH        16
`define TMR_COUNT_RESET  16'h0000
`define TMR_COUNT_MAX    16'hFFFF
`define TMR_ONE          16'h0001
`define TMR_CMP_RESET    16'hFFFF
`define TMR_CAP_RESET    16'h0000
`define TMR_MODE_FREE    2'h0
`define TMR_MODE_CLR_CMP 2'h1
`define TMR_MODE_CLR_EDG 2'h2
`endif

// file: timer16_pkg.sv
// types for the 16-bit compare/capture timer
`default_nettype none
package timer16_pkg;
    typedef enum logic [1:0] {
        MODE_FREE    = 2'h0,
        MODE_CLR_CMP = 2'h1,
        MODE_CLR_EDG = 2'h2,
        MODE_STOP    = 2'h3
    } mode_t;
endpackage : timer16_pkg
`default_nettype wire

// file: timer16_edge_sync.sv
// two-stage synchroniser with rising-edge pulse for the edge input
`timescale 1ns/1ps
`default_nettype none
module timer16_edge_sync (
    // clock and reset
    input  wire logic CLK_SYS,
    input  wire logic RESET_N,
    // pin in, pulse out
    input  wire logic PIN_IN,
    output logic      RISE
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } sync_t;
    sync_t st;
    sync_t next_st;

    always_comb begin
        next_st    = st;
        next_st.s1 = PIN_IN;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign RISE = st.s2 & ~st.s3;
endmodule : timer16_edge_sync
`default_nettype wire

// file: timer16_compare_capture.sv
// 16-bit up-counter with compare/capture and secondary capture
// Operation
// R1 - counter read never loads the secondary capture
// R2 - count clock held off during reads
// R3 - clear-on-match mode needs nonzero compare value
// R4 - zero compare matches on 0000H to 0001H
// R5 - compare below count: overflow before match
// R6 - software restarts timer after lowering compare
// R7 - 16-bit counter wraps from maximum to zero
`timescale 1ns/1ps
`default_nettype none
`include "timer16_regs.svh"
module timer16_compare_capture (
    // clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RESET_N,
    // control
    input  wire logic [1:0]  MODE,
    input  wire logic        COUNT_EN,
    input  wire logic        CMP_WE,
    input  wire logic [15:0] CMP_WDATA,
    input  wire logic        COUNT_RD,
    input  wire logic        CAPTURE_TRIG,
    // external pin
    input  wire logic        EXTERNAL_EDGE_INPUT,
    // results
    output logic [15:0]      TIMER_COUNT_VALUE,
    output logic [15:0]      CAPTURE_COMPARE_PRIMARY,
    output logic [15:0]      CAPTURE_SECONDARY,
    output logic [15:0]      READ_DATA,
    output logic             COMPARE_MATCH_INTERRUPT
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] cmp;
        logic [15:0] cap2;
        logic [15:0] rdata;
        logic        pend;
        logic        irq;
        logic        wrapped;
    } state_t;
    state_t st;
    state_t next_st;
    logic   edge_rise;
    timer16_pkg::mode_t mode;

    timer16_edge_sync u_sync (
        .CLK_SYS (CLK_SYS),
        .RESET_N (RESET_N),
        .PIN_IN  (EXTERNAL_EDGE_INPUT),
        .RISE    (edge_rise)
    );

    assign mode = timer16_pkg::mode_t'(MODE);

    // ----------------------------------------
    // decoding
    // ----------------------------------------
    // true while the selected mode lets ticks reach the counter
    function automatic logic runs(input timer16_pkg::mode_t m);
        return m != timer16_pkg::MODE_STOP;
    endfunction : runs

    // ----------------------------------------
    // counting, compare and capture
    // ----------------------------------------
    always_comb begin
        logic        tick;
        logic        req;
        logic [15:0] nxt;
        logic        match;
        tick    = 1'b0;
        req     = 1'b0;
        nxt     = 16'h0000;
        match   = 1'b0;
        next_st = st;
        next_st.irq = 1'b0;
        // a tick that lands on a read waits in pend, one step at a time,
        // so a steady count clock lags by one but never drops a tick [R2]
        req = COUNT_EN & runs(mode);
        if (COUNT_RD) begin
            next_st.rdata = st.count;
            next_st.pend  = req;                          // [R2]
            tick          = st.pend;
        end else begin
            next_st.pend = st.pend & req;                 // [R2]
            tick         = st.pend | req;
        end
        if (!COUNT_EN && !runs(mode)) begin
            next_st.count   = `TMR_COUNT_RESET;
            next_st.wrapped = 1'b0;
            next_st.pend    = 1'b0;
            tick            = 1'b0;
        end
        if (tick) begin
            nxt = st.count + `TMR_ONE;                    // [R7]
            if (st.count == `TMR_COUNT_MAX) begin
                next_st.wrapped = 1'b1;                   // [R5]
            end
            // zero compare fires on the step 0000H to 0001H once wrapped is set, never in MODE_CLR_CMP [R4]
            if (st.cmp == `TMR_COUNT_RESET) begin
                match = (nxt == `TMR_ONE) && st.wrapped
                        && (mode != timer16_pkg::MODE_CLR_CMP);
            end else begin
                // lower value only met after the wrap [R5]
                match = (nxt == st.cmp);
            end
            next_st.irq   = match;
            next_st.count = nxt;
            if (match && mode == timer16_pkg::MODE_CLR_CMP) begin
                next_st.count = `TMR_COUNT_RESET;         // [R3]
            end
        end
        if (edge_rise && mode == timer16_pkg::MODE_CLR_EDG) begin
            next_st.count = `TMR_COUNT_RESET;
        end
        // secondary capture only on its trigger, never a read [R1]
        if (CAPTURE_TRIG) begin
            next_st.cap2 = st.count;
        end
        if (CMP_WE) begin
            next_st.cmp = CMP_WDATA;                      // [R6]
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            st.count   <= `TMR_COUNT_RESET;
            st.cmp     <= `TMR_CMP_RESET;
            st.cap2    <= `TMR_CAP_RESET;
            st.rdata   <= `TMR_COUNT_RESET;
            st.pend    <= 1'b0;
            st.irq     <= 1'b0;
            st.wrapped <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign TIMER_COUNT_VALUE       = st.count;
    assign CAPTURE_COMPARE_PRIMARY = st.cmp;
    assign CAPTURE_SECONDARY       = st.cap2;
    assign READ_DATA               = st.rdata;
    assign COMPARE_MATCH_INTERRUPT = st.irq;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_READ_NO_CAPTURE: assert property ( // [R1]
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (COUNT_RD && !CAPTURE_TRIG) |=> $stable(st.cap2))
        else $error("secondary capture changed on a plain read");
    AST_READ_HOLDS_TICK: assert property ( // [R2]
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (COUNT_RD && COUNT_EN && mode == timer16_pkg::MODE_FREE
         && !CMP_WE) |=> st.pend)
        else $error("tick during read was dropped");
    AST_PEND_RELEASED: assert property ( // [R2]
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (st.pend && !COUNT_RD && !COUNT_EN
         && mode == timer16_pkg::MODE_FREE && !edge_rise) |=> !st.pend)
        else $error("deferred tick not released");
    AST_PEND_KEPT: assert property ( // [R2]
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (st.pend && !COUNT_RD && COUNT_EN
         && mode == timer16_pkg::MODE_FREE) |=> st.pend)
        else $error("second tick after a read was dropped");
    AST_NO_COUNT_ON_READ: assert property ( // [R2]
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (COUNT_RD && !st.pend && mode == timer16_pkg::MODE_FREE)
        |=> st.count == $past(st.count))
        else $error("counter moved during a read");
    AST_READ_DATA: assert property ( // [R2]
        @(posedge CLK_SYS) disable iff (!RESET_N)
        COUNT_RD |=> READ_DATA == $past(st.count))
        else $error("read data is not the count at the read");
    AST_WRAP: assert property ( // [R7]
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (st.count == 16'hFFFF && COUNT_EN && !COUNT_RD
         && mode == timer16_pkg::MODE_FREE)
        |=> st.count == 16'h0000)
        else $error("counter did not wrap to zero");
    AST_ZERO_CMP_IRQ: assert property ( // [R4]
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (st.cmp == 16'h0000 && st.wrapped && st.count == 16'h0000
         && COUNT_EN && !COUNT_RD && mode == timer16_pkg::MODE_FREE)
        |=> COMPARE_MATCH_INTERRUPT)
        else $error("zero compare missed its interrupt");
    AST_NO_EARLY_ZERO_IRQ: assert property ( // [R4]
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (st.cmp == 16'h0000 && !st.wrapped) |=> !COMPARE_MATCH_INTERRUPT)
        else $error("zero compare fired before overflow");
    AST_CLR_ON_MATCH: assert property ( // [R3]
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (mode == timer16_pkg::MODE_CLR_CMP && st.cmp != 16'h0000
         && st.count + 16'h0001 == st.cmp && COUNT_EN && !COUNT_RD
         && !edge_rise) |=> (st.count == 16'h0000 && st.irq))
        else $error("clear on match failed");
    AST_LOW_CMP_NO_MATCH: assert property ( // [R5]
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (st.cmp != 16'h0000 && st.count >= st.cmp
         && st.count != 16'hFFFF) |=> !COMPARE_MATCH_INTERRUPT)
        else $error("match before overflow with low compare");
    AST_CAPTURE: assert property ( // [R1]
        @(posedge CLK_SYS) disable iff (!RESET_N)
        CAPTURE_TRIG |=> CAPTURE_SECONDARY == $past(st.count))
        else $error("secondary capture missed its trigger");
    AST_TICK_STEP: assert property ( // [R7]
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (COUNT_EN && !COUNT_RD && mode == timer16_pkg::MODE_FREE)
        |=> st.count == $past(st.count) + 16'h0001)
        else $error("counter did not step by one");
    AST_CMP_LOAD: assert property ( // [R6]
        @(posedge CLK_SYS) disable iff (!RESET_N)
        CMP_WE |=> CAPTURE_COMPARE_PRIMARY == $past(CMP_WDATA))
        else $error("compare write did not land");
    AST_STOP_CLEARS: assert property ( // [R7]
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (mode == timer16_pkg::MODE_STOP && !COUNT_EN)
        |=> (st.count == 16'h0000 && !st.wrapped))
        else $error("stop did not clear the counter");
    AST_EDGE_CLEAR: assert property ( // [R4]
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (edge_rise && mode == timer16_pkg::MODE_CLR_EDG)
        |=> st.count == 16'h0000)
        else $error("pin edge did not clear the counter");
endmodule : timer16_compare_capture
`default_nettype wire

// file: timer16_compare_capture_tb_top.sv
// self-checking testbench for the 16-bit compare/capture timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin \
    err_total++; $display("[FAIL] %s exp %h got %h", nm, exp, got); end end
module timer16_compare_capture_tb_top;
    logic        clk_sys;
    logic        reset_n;
    logic [1:0]  mode;
    logic        count_en;
    logic        cmp_we;
    logic [15:0] cmp_wdata;
    logic        count_rd;
    logic        capture_trig;
    logic        edge_pin;
    logic [15:0] count;
    logic [15:0] primary;
    logic [15:0] secondary;
    logic [15:0] read_data;
    logic        irq;
    int          err_total;
    int          checks_done;
    int          cycles;

    timer16_compare_capture uut (
        .CLK_SYS(clk_sys), .RESET_N(reset_n), .MODE(mode),
        .COUNT_EN(count_en), .CMP_WE(cmp_we), .CMP_WDATA(cmp_wdata),
        .COUNT_RD(count_rd), .CAPTURE_TRIG(capture_trig),
        .EXTERNAL_EDGE_INPUT(edge_pin), .TIMER_COUNT_VALUE(count),
        .CAPTURE_COMPARE_PRIMARY(primary), .CAPTURE_SECONDARY(secondary),
        .READ_DATA(read_data), .COMPARE_MATCH_INTERRUPT(irq));

    // ------------------------------------------------------------
    // clock, timeout and closing report
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 70000) begin
            err_total++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (err_total == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------
    // drivers, called and returning at a falling edge
    // ------------------------------------------------------------
    task automatic cyc(input logic en, input logic rd);
        count_en = en;
        count_rd = rd;
        @(negedge clk_sys);
    endtask : cyc

    task automatic restart(input logic [1:0] m);
        mode = timer16_pkg::MODE_STOP;
        cyc(1'b0, 1'b0);
        mode = m;
    endtask : restart

    task automatic wr_cmp(input logic [15:0] v);
        cmp_we = 1'b1;
        cmp_wdata = v;
        cyc(1'b0, 1'b0);
        cmp_we = 1'b0;
    endtask : wr_cmp

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_read();
        restart(timer16_pkg::MODE_FREE);
        repeat (3) cyc(1'b1, 1'b0);
        cyc(1'b1, 1'b1);
        `CHK("read data", 16'h0003, read_data)
        `CHK("count held", 16'h0003, count)
        `CHK("no capture on read", 16'h0000, secondary)
        cyc(1'b0, 1'b0);
        `CHK("deferred tick", 16'h0004, count)
        capture_trig = 1'b1;
        cyc(1'b0, 1'b0);
        capture_trig = 1'b0;
        `CHK("capture", 16'h0004, secondary)
        cyc(1'b1, 1'b1);
        cyc(1'b1, 1'b0);
        `CHK("lag during steady count", 16'h0005, count)
        cyc(1'b0, 1'b0);
        `CHK("no tick lost", 16'h0006, count)
    endtask : t_read

    task automatic t_clear();
        restart(timer16_pkg::MODE_CLR_CMP);
        wr_cmp(16'h0003);
        repeat (2) cyc(1'b1, 1'b0);
        `CHK("before match", 1'b0, irq)
        cyc(1'b1, 1'b0);
        `CHK("cleared on match", 16'h0000, count)
        `CHK("match irq", 1'b1, irq)
        cyc(1'b0, 1'b0);
        `CHK("irq one cycle", 1'b0, irq)
    endtask : t_clear

    task automatic t_wrap();
        int hits;
        restart(timer16_pkg::MODE_FREE);
        repeat (5) cyc(1'b1, 1'b0);
        wr_cmp(16'h0000);
        hits = 0;
        repeat (65530) begin
            cyc(1'b1, 1'b0);
            if (irq !== 1'b0) hits++;
        end
        `CHK("count at max", 16'hFFFF, count)
        `CHK("no early match", 0, hits)
        cyc(1'b1, 1'b0);
        `CHK("wrapped", 16'h0000, count)
        `CHK("no irq at wrap", 1'b0, irq)
        cyc(1'b1, 1'b0);
        `CHK("zero match irq", 1'b1, irq)
    endtask : t_wrap

    task automatic t_edge();
        restart(timer16_pkg::MODE_CLR_EDG);
        repeat (4) cyc(1'b1, 1'b0);
        wr_cmp(16'h0002);
        restart(timer16_pkg::MODE_CLR_EDG);
        `CHK("count after restart", 16'h0000, count)
        `CHK("new compare", 16'h0002, primary)
        repeat (2) cyc(1'b1, 1'b0);
        `CHK("match at new value", 1'b1, irq)
        edge_pin = 1'b1;
        repeat (2) cyc(1'b0, 1'b0);
        `CHK("pin edge in sync", 16'h0002, count)
        cyc(1'b0, 1'b0);
        `CHK("pin edge clear", 16'h0000, count)
        edge_pin = 1'b0;
    endtask : t_edge

    initial begin
        err_total = 0;
        checks_done = 0;
        cycles = 0;
        reset_n = 1'b0;
        mode = timer16_pkg::MODE_FREE;
        count_en = 1'b0;
        cmp_we = 1'b0;
        cmp_wdata = 16'h0000;
        count_rd = 1'b0;
        capture_trig = 1'b0;
        edge_pin = 1'b0;
        repeat (2) @(negedge clk_sys);
        reset_n = 1'b1;
        `CHK("count reset", 16'h0000, count)
        t_read();
        t_clear();
        t_wrap();
        t_edge();
        end_of_test();
    end
endmodule : timer16_compare_capture_tb_top
`default_nettype wire
